// ==== dos_pkg.sv ====
// package for the door opener sequencer: states and timing constants
// assumes a single 100 MHz core clock
package dos_pkg;

  // ****************************************************************
  // door states
  // ****************************************************************
  typedef enum logic [2:0] {
    DOS_DOWN,
    DOS_PUSH_UP,
    DOS_RAISING,
    DOS_UP,
    DOS_PUSH_DOWN,
    DOS_LOWERING
  } dos_state_t;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_MS = 100;
  localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LIGHT_PRESET   = 1800;

endpackage : dos_pkg

// ==== dos_light_timer.sv ====
// light timer: counts 0.1 s ticks while enabled, done at preset
// assumes the enable drops for a cycle once done is seen
`timescale 1ns/1ns
`default_nettype none
module dos_light_timer
  import dos_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int PRESET_P      = LIGHT_PRESET
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // control
  input  wire logic enable,
  output var  logic done
);

  // count is 16 bits wide, so a larger preset could never be reached
  if (TICK_CYCLES_P < 1 || PRESET_P < 1 || PRESET_P > 32'h0000FFFF) begin : g_bad_params
    $error("timer counts out of range");
  end

  logic [31:0] tick_cnt;
  logic [15:0] count;

  // ****************************************************************
  // prescaler and accumulator
  // ****************************************************************
  // accumulates only while enabled; cleared when idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      count    <= 16'h0;
    end else if (!enable) begin
      tick_cnt <= 32'h0;
      count    <= 16'h0;
    end else if (tick_cnt == 32'(TICK_CYCLES_P - 1)) begin
      tick_cnt <= 32'h0;
      if (count != 16'(PRESET_P)) begin
        count <= count + 16'h1;
      end
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  assign done = enable && (count == 16'(PRESET_P));

endmodule : dos_light_timer
`default_nettype wire

// ==== dos_sequencer.sv ====
// door opener sequencer: door state machine plus parallel light state
// assumes inputs synchronous to core_clk, one clock equals one scan
//
// Notes on behaviour
// - door-down waits for button; press then release leads to raising
// - raising state drives the raise command
// - up limit moves raising to door-up, dropping raise
// - door-up waits for press and release, then lowers
// - down limit returns lowering to door-down, obstruction permitting
// - release in push-up starts raising, and the light too unless timer done falls in that scan
// - release in push-down starts lowering, and the light too unless timer done falls in that scan
// - light state drives the light and times 0.1 s counts to 1800
// - timer accumulates only in light state, done at preset
// - timer done clears the light state and goes nowhere else
// - door transitions run independently of the light state
// - obstruction while lowering goes to push-up, not raising
// - down exit needs no obstruction; obstruction reversal wins
// - the initial state is active at reset, then behaves normally
`timescale 1ns/1ns
`default_nettype none
module dos_sequencer
  import dos_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int PRESET_P      = LIGHT_PRESET
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // door inputs
  input  wire logic door_command_button,
  input  wire logic up_travel_limit,
  input  wire logic down_travel_limit,
  input  wire logic obstruction_sense,
  // motor and light outputs
  output var  logic raise_command,
  output var  logic lower_command,
  output var  logic safety_light_output
);

  // ****************************************************************
  // state
  // ****************************************************************
  dos_state_t state;
  dos_state_t next_state;
  logic       light_state;
  logic       light_timer_done;
  logic       light_set;

  // ****************************************************************
  // door transitions
  // ****************************************************************
  always_comb begin
    next_state = state;
    light_set  = 1'b0;
    unique case (state)
      DOS_DOWN: begin
        if (door_command_button) next_state = DOS_PUSH_UP;
      end
      DOS_PUSH_UP: begin
        if (!door_command_button) begin
          next_state = DOS_RAISING;
          light_set  = 1'b1;
        end
      end
      DOS_RAISING: begin
        if (up_travel_limit) next_state = DOS_UP;
      end
      DOS_UP: begin
        if (door_command_button) next_state = DOS_PUSH_DOWN;
      end
      DOS_PUSH_DOWN: begin
        if (!door_command_button) begin
          next_state = DOS_LOWERING;
          light_set  = 1'b1;
        end
      end
      DOS_LOWERING: begin
        // reversal first so only one exit is ever taken
        if (obstruction_sense) next_state = DOS_PUSH_UP;
        else if (down_travel_limit) next_state = DOS_DOWN;
      end
    endcase
  end

  // door state never looks at the light
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DOS_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // motor outputs
  // ****************************************************************
  // registered from next state; push-up drops lower a scan before raise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raise_command <= 1'b0;
      lower_command <= 1'b0;
    end else begin
      raise_command <= (next_state == DOS_RAISING);
      lower_command <= (next_state == DOS_LOWERING);
    end
  end

  // ****************************************************************
  // parallel light state
  // ****************************************************************
  // a new set while already lit keeps the running period untouched
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      light_state <= 1'b0;
    end else if (light_timer_done) begin
      light_state <= 1'b0;
    end else if (light_set) begin
      light_state <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      safety_light_output <= 1'b0;
    end else begin
      safety_light_output <= light_timer_done ? 1'b0 : (light_state | light_set);
    end
  end

  dos_light_timer #(
    .TICK_CYCLES_P (TICK_CYCLES_P),
    .PRESET_P      (PRESET_P)
  ) u_light_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (light_state),
    .done     (light_timer_done)
  );

  // ****************************************************************
  // door checks
  // ****************************************************************
  never_both_cmd_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !(raise_command && lower_command))
    else $error("raise and lower together");

  raise_tracks_state_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    raise_command == (state == DOS_RAISING))
    else $error("raise mismatch");

  lower_tracks_state_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    lower_command == (state == DOS_LOWERING))
    else $error("lower mismatch");

  press_entry_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_DOWN && door_command_button) |=> state == DOS_PUSH_UP)
    else $error("press not taken");

  down_hold_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_DOWN && !door_command_button) |=> state == DOS_DOWN)
    else $error("door down left without press");

  // a release on the done cycle loses to the clear, so the light may stay off
  press_release_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_PUSH_UP && !door_command_button) |=>
      (state == DOS_RAISING && (light_state || $past(light_timer_done))))
    else $error("release did not raise and light");

  raise_hold_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_RAISING && !up_travel_limit) |=> (state == DOS_RAISING && raise_command))
    else $error("raising left without up limit");

  up_limit_stop_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_RAISING && up_travel_limit) |=> (state == DOS_UP && !raise_command))
    else $error("up limit did not stop");

  up_press_entry_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_UP && door_command_button) |=> state == DOS_PUSH_DOWN)
    else $error("press in door up not taken");

  up_hold_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_UP && !door_command_button) |=> state == DOS_UP)
    else $error("door up left without press");

  push_down_light_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_PUSH_DOWN && !door_command_button) |=>
      (state == DOS_LOWERING && (light_state || $past(light_timer_done))))
    else $error("release did not lower and light");

  push_no_motor_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_PUSH_UP || state == DOS_PUSH_DOWN) |-> (!raise_command && !lower_command))
    else $error("motor driven in a push state");

  obstruct_reverse_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_LOWERING && obstruction_sense) |=>
      (state == DOS_PUSH_UP && !raise_command && !lower_command))
    else $error("obstruction not reversed");

  down_limit_exit_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_LOWERING && down_travel_limit && !obstruction_sense) |=>
      (state == DOS_DOWN && !lower_command))
    else $error("down limit ignored");

  lower_hold_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == DOS_LOWERING && !down_travel_limit && !obstruction_sense) |=>
      (state == DOS_LOWERING && lower_command))
    else $error("lowering left without cause");

  // ****************************************************************
  // light checks
  // ****************************************************************
  light_off_done_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    light_timer_done |=> (!light_state && !safety_light_output))
    else $error("light not cleared at done");

  light_follows_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(light_state) |-> safety_light_output)
    else $error("light output lags");

  light_output_match_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    safety_light_output == light_state)
    else $error("light output differs from light state");

  light_done_only_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    light_timer_done |-> light_state)
    else $error("timer done outside light state");

  // only the timer may end the light, whatever the door does meanwhile
  light_drop_cause_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $fell(light_state) |-> $past(light_timer_done))
    else $error("light dropped without timer done");

  light_set_takes_a : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (light_set && !light_timer_done) |=> light_state)
    else $error("light set not taken");

endmodule : dos_sequencer
`default_nettype wire

// ==== dos_door_model.sv ====
// door model: motor moves a position count, limit switches at the ends
// assumes raise and lower come from the sequencer, user inputs from the bench
`timescale 1ns/1ns
`default_nettype none
module dos_door_model #(
  parameter int TRAVEL = 4
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // motor commands and user inputs
  input  wire logic raise_command,
  input  wire logic lower_command,
  input  wire logic wall_button,
  input  wire logic remote_button,
  input  wire logic object_present,
  // sensed lines
  output var  logic door_command_button,
  output var  logic up_travel_limit,
  output var  logic down_travel_limit,
  output var  logic obstruction_sense
);
  // ****************************************************************
  // motor and switches
  // ****************************************************************
  int pos;
  // both commands at once would be a fault, so the motor holds still then
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 0;
    end else if (raise_command && !lower_command && pos < TRAVEL) begin
      pos <= pos + 1;
    end else if (lower_command && !raise_command && pos > 0) begin
      pos <= pos - 1;
    end
  end
  assign up_travel_limit     = (pos == TRAVEL);
  assign down_travel_limit   = (pos == 0);
  assign door_command_button = wall_button | remote_button;
  assign obstruction_sense   = object_present;
endmodule : dos_door_model
`default_nettype wire

// ==== tb_top.sv ====
// testbench: steps the door through its cycles against the door model
// assumes a short tick and preset so the light period is a few cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0d got %0d", nm, exp, got); end end
module tb_top;
  import dos_pkg::*;
  localparam int TICK_P = 2;
  localparam int PRE_P  = 3;
  logic core_clk = 1'h0;
  logic rst_n    = 1'h0;
  logic wall     = 1'h0;
  logic remote   = 1'h0;
  logic obj      = 1'h0;
  logic btn, up_lim, dn_lim, obs, raise_command, lower_command, light;
  int   n_errors, num_checks, cycles, cnt;
  // row: wall, remote, object, expected raise, expected lower, cycles[2:0]
  logic [7:0] rows [22] = '{8'h81, 8'h11, 8'h05, 8'h41, 8'h09, 8'h0A, 8'h21, 8'h11,
    8'h04, 8'h81, 8'h09, 8'h0C, 8'h21, 8'h11, 8'h91, 8'h04, 8'h81, 8'h09, 8'h05,
    8'h22, 8'h81, 8'h11};
  dos_sequencer #(.TICK_CYCLES_P(TICK_P), .PRESET_P(PRE_P)) dos_sequencer_inst (
    .core_clk(core_clk), .rst_n(rst_n), .door_command_button(btn),
    .up_travel_limit(up_lim), .down_travel_limit(dn_lim), .obstruction_sense(obs),
    .raise_command(raise_command), .lower_command(lower_command),
    .safety_light_output(light));
  dos_door_model #(.TRAVEL(4)) dos_door_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .raise_command(raise_command),
    .lower_command(lower_command), .wall_button(wall), .remote_button(remote),
    .object_present(obj), .door_command_button(btn), .up_travel_limit(up_lim),
    .down_travel_limit(dn_lim), .obstruction_sense(obs));
  always #5 core_clk = ~core_clk;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // inputs change 1 ns after the edge, outputs sampled 1 ns after the last edge
  task automatic step(input logic [7:0] r);
    wall   = r[7];
    remote = r[6];
    obj    = r[5];
    repeat (r[2:0]) @(posedge core_clk);
    #1;
    `CHK("raise", r[4], raise_command)
    `CHK("lower", r[3], lower_command)
  endtask : step
  // press and release, then count the cycles the light stays on
  task automatic light_run(input logic [7:0] rel);
    step(8'h81);
    step(rel);
    cnt = int'(light === 1'h1);
    repeat (14) begin
      @(posedge core_clk);
      #1;
      cnt += int'(light === 1'h1);
    end
    `CHK("light cycles", PRE_P * TICK_P + 1, cnt)
  endtask : light_run
  // ****************************************************************
  // sequence
  // ****************************************************************
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 500) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("outs in reset", 3'h0, {raise_command, lower_command, light})
    rst_n = 1'h1;
    foreach (rows[i]) begin
      step(rows[i]);
    end
    // reset while raising and lit must drop every output at once
    rst_n = 1'h0;
    #1;
    `CHK("outs after reset", 3'h0, {raise_command, lower_command, light})
    @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    light_run(8'h11);
    `CHK("door up", 1'h1, up_lim)
    light_run(8'h09);
    `CHK("door down", 1'h1, dn_lim)
    final_report();
  end
endmodule : tb_top
`default_nettype wire
